// >>> verilog/dbc_pkg.sv
// Constants, field layouts and types for the device bay status block
package dbc_pkg;

   // Register offsets (byte addresses on the internal register port)
   localparam logic [7:0] OFS_CTL0 = 8'h10; // Bay 0 control
   localparam logic [7:0] OFS_STS0 = 8'h14; // Bay 0 status
   localparam logic [7:0] OFS_CTL1 = 8'h18; // Bay 1 control
   localparam logic [7:0] OFS_STS1 = 8'h20; // Bay 1 status
   localparam logic [7:0] OFS_CFG = 8'h0c; // Controller config
   localparam logic [7:0] OFS_FEAT = 8'hfc; // Feature configuration

   // Values after reset
   localparam logic [31:0] CFG_RESET = 32'h00000002; // Two bays, no locks
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] FEAT_RESET = 8'h00;
   localparam logic [31:0] CNT_RESET = 32'h00000000;

   // Status field positions for write-one-to-clear
   localparam int STS_REMREQ_BIT = 3;
   localparam int STS_CHG_BIT = 2;

   // Timing: oscillator rate and nominal durations
   localparam int CLK_HZ = 40000000; // core_clk rate
   localparam int TICK_MS = 50; // Debounce and short pulse unit
   localparam int LONG_MS = 800; // Timeout and long pulse unit
   localparam logic [31:0] TICK_CYCLES = 32'(CLK_HZ / 1000 * TICK_MS);
   localparam logic [31:0] LONG_PER_TICK = 32'(LONG_MS / TICK_MS);
   localparam logic [1:0] POR_HOLD_CYCLES = 2'h2; // Power-up hold

   // Bay state encoding
   typedef enum logic [2:0] {
      ST_EMPTY = 3'h0,
      ST_INSERTED = 3'h1,
      ST_ENABLED = 3'h2,
      ST_REM_REQUESTED = 3'h3,
      ST_REM_ALLOWED = 3'h4
   } dbc_bay_state_type;

   // Bay control register, low byte
   typedef struct packed {
      logic lock; // Lock control bit
      logic [2:0] streq; // Requested bay state
      logic removal_request_irq_enable; // Removal request irq enable
      logic chg_en; // Bay change enable
      logic wake_en; // Removal wake enable
      logic pwr; // Power control
   } dbc_ctl_type;

   // Bay status register, low byte
   typedef struct packed {
      logic sl_sts; // Security lock, locks off so zero
      logic [2:0] state; // Actual bay state
      logic remreq; // Removal request flag
      logic chg; // Bay change flag
      logic ser_present; // Serial bus present flag
      logic per_present; // Peripheral present flag
   } dbc_sts_type;

   // Feature configuration register, low byte
   typedef struct packed {
      logic [2:0] wait_units; // Insertion timeout field
      logic [3:0] pulse_units; // Solenoid pulse count
      logic long_sel; // Solenoid long pulse select
   } dbc_feat_type;

endpackage

// >>> verilog/dbc_bay_status.sv
// Two-bay status, control and feature configuration logic
`timescale 1ns/100ps

//Operation
// - Removal request pin falling with device seated sets sticky flag
// - Enabled request moves bay to Removal Allowed
// - Insert or remove event sets sticky change flag
// - Removal sets change flag unless unwakeable allowed
// - Enabled insertion moves bay to Device Inserted
// - Presence bits read inverse of presence pins
// - Feature register upper 24 bits read zero
// - Feature fields accept only first write
// - Insertion wait is timeout field times 800ms
// - Presence debounced 50ms before timeout starts
// - Zero count gives level mode solenoid drive
// - Nonzero count pulses on lock one-to-zero
// - Pulse is count times 50ms or 800ms
// - Feature layout timeout, count, long select
// - First feature write clears locks and solenoids
// - Internal reset ORs pin and power-on reset
// - Power-up holds reset two more cycles
// - Reset clears registers, outputs, sets config
// - Reset restores write-once, samples address, pointer
// - Bay state codes 000 to 100
module dbc_bay_status #(
   parameter logic [31:0] TICK_CYCLES = dbc_pkg::TICK_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic reset_pin_n,
   input wire logic [1:0] removal_request_pin_n,
   input wire logic [1:0] serial_bus_present_pin_n,
   input wire logic [1:0] peripheral_present_pin_n,
   input wire logic address_select_low_pin,
   input wire logic address_select_high_pin,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   output logic [31:0] reg_rdata,
   output logic alert_output,
   output logic [1:0] power_enable_output,
   output logic [1:0] solenoid_drive_output,
   output logic [1:0] slave_addr_select,
   output logic pointer_reset
);

   // Long unit is sixteen short units, shortened along with the tick
   localparam logic [31:0] LONG_CYCLES =
      32'(TICK_CYCLES * dbc_pkg::LONG_PER_TICK);
   localparam logic [7:0] OFS_CTL [2] = '{dbc_pkg::OFS_CTL0,
                                          dbc_pkg::OFS_CTL1};
   localparam logic [7:0] OFS_STS [2] = '{dbc_pkg::OFS_STS0,
                                          dbc_pkg::OFS_STS1};

   // Pin synchronisers: stage one feeds stage two only
   logic [8:0] pin_s1; // First stage
   logic [8:0] pin_s2; // Second stage, the only one logic reads
   logic [8:0] pin_raw; // Gathered asynchronous pins
   logic ext_reset_n; // Synced reset pin
   logic [1:0] rr_n; // Synced removal request pins
   logic [1:0] ser_n; // Synced serial bus presence pins
   logic [1:0] per_n; // Synced peripheral presence pins
   logic [1:0] ad_sync; // Synced address select pins

   // Reset generation
   logic [1:0] por_cnt; // Power-up hold countdown
   logic int_rst; // Combined internal reset

   // Feature register state
   dbc_pkg::dbc_feat_type feat; // Stored feature byte
   logic feat_locked; // Write-once permission spent
   logic wr_feat; // Feature register write strobe
   logic lock_wipe; // First feature write clears locks
   logic pulsed; // Solenoid pulse mode

   // Per-bay views for the read mux and alert
   logic [7:0] ctl_word [2]; // Control bytes
   logic [7:0] sts_word [2]; // Status bytes
   logic alert_term [2]; // Enabled pending flags per bay
   logic sol_drive [2]; // Solenoid drive flops
   logic pwr_drive [2]; // Power enable flops
   logic [31:0] next_rdata; // Read mux result

   assign pin_raw = {reset_pin_n, removal_request_pin_n,
                     serial_bus_present_pin_n, peripheral_present_pin_n,
                     address_select_high_pin, address_select_low_pin};
   assign ext_reset_n = pin_s2[8];
   assign rr_n = pin_s2[7:6];
   assign ser_n = pin_s2[5:4];
   assign per_n = pin_s2[3:2];
   assign ad_sync = pin_s2[1:0];

   // Two-flop synchroniser, idle high like the pulled-up pins
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pin_s1 <= '1;
         pin_s2 <= '1;
      end else begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
      end
   end

   // Power-up hold counter, runs once after the oscillator starts
   always_ff @(posedge core_clk) begin
      if (rst) begin
         por_cnt <= dbc_pkg::POR_HOLD_CYCLES;
      end else if (por_cnt != 2'h0) begin
         por_cnt <= por_cnt - 2'h1;
      end
   end

   // Internal reset: power-on OR pin, then held while pin stays low
   always_ff @(posedge core_clk) begin
      if (rst) begin
         int_rst <= 1'b1;
      end else begin
         int_rst <= (por_cnt != 2'h0) | ~ext_reset_n;
      end
   end

   // Bus engine zeroes its address pointer while this is high
   assign pointer_reset = int_rst;

   // Slave address sampled from the straps throughout reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         slave_addr_select <= 2'h0;
      end else if (int_rst) begin
         slave_addr_select <= ad_sync;
      end
   end

   // Feature register decode
   assign wr_feat = reg_wr & (reg_addr == dbc_pkg::OFS_FEAT);
   assign lock_wipe = wr_feat & ~feat_locked;
   assign pulsed = feat.pulse_units != 4'h0;

   // Write-once feature byte; reset restores permission
   always_ff @(posedge core_clk) begin
      if (int_rst) begin
         feat <= dbc_pkg::FEAT_RESET;
         feat_locked <= 1'b0;
      end else if (wr_feat & ~feat_locked) begin
         feat <= reg_wdata[7:0];
         feat_locked <= 1'b1;
      end
   end

   // One copy of the bay logic per bay
   for (genvar b = 0; b < 2; b++) begin : g_bay
      dbc_pkg::dbc_ctl_type ctl; // Control byte
      dbc_pkg::dbc_ctl_type next_ctl; // Next control byte
      dbc_pkg::dbc_ctl_type wr_val; // Written control byte
      dbc_pkg::dbc_bay_state_type state; // Actual bay state
      dbc_pkg::dbc_bay_state_type next_state;
      logic remreq_flag; // Sticky removal request
      logic chg_flag; // Sticky bay change
      logic present_raw; // Either presence pin active
      logic present_db; // Debounced presence
      logic [31:0] deb_cnt; // Debounce timer
      logic waiting; // Insertion timeout running
      logic seated; // Device registered in bay
      logic [31:0] wait_cnt; // Insertion timeout countdown
      logic [31:0] wait_len; // Programmed insertion wait
      logic [31:0] pulse_len; // Programmed solenoid pulse
      logic [31:0] pulse_cnt; // Solenoid pulse countdown
      logic rr_prev; // Removal request pin last cycle
      logic wr_ctl; // Control write strobe
      logic wr_sts; // Status write strobe
      logic deb_done; // Debounce period elapsed
      logic ins_start; // Debounced insertion seen
      logic ins_fire; // Insertion timeout elapsed
      logic rem_evt; // Debounced removal of a seated device
      logic cancel; // Removal during timeout, no event
      logic remreq_evt; // Button press with device seated
      logic chg_set; // Hardware sets change flag
      logic streq_ok; // Accepted state request
      logic lock_fall; // Lock bit written from one to zero

      assign wr_ctl = reg_wr & (reg_addr == OFS_CTL[b]);
      assign wr_sts = reg_wr & (reg_addr == OFS_STS[b]);
      assign wr_val = reg_wdata[7:0];
      assign present_raw = ~ser_n[b] | ~per_n[b];
      assign deb_done = (present_raw != present_db) &
                        (deb_cnt == TICK_CYCLES - 32'h1);
      assign ins_start = deb_done & present_raw;
      assign cancel = deb_done & ~present_raw & waiting;
      assign rem_evt = deb_done & ~present_raw & seated;
      assign ins_fire = waiting & (wait_cnt == 32'h0);
      assign remreq_evt = rr_prev & ~rr_n[b] & seated;
      // Removal from an unwakeable Removal Allowed bay stays silent
      assign chg_set = ins_fire | (rem_evt &
         ~(~ctl.wake_en & (state == dbc_pkg::ST_REM_ALLOWED)));
      assign wait_len = {29'h0, feat.wait_units} * LONG_CYCLES;
      assign pulse_len = {28'h0, feat.pulse_units} *
                         (feat.long_sel ? LONG_CYCLES : TICK_CYCLES);
      assign streq_ok = wr_ctl & seated & (wr_val.streq != 3'h0) &
                        (wr_val.streq <= 3'h4);
      assign lock_fall = wr_ctl & ctl.lock & ~wr_val.lock;

      // Control byte next value
      always_comb begin
         next_ctl = ctl;
         if (wr_ctl) begin
            next_ctl.lock = wr_val.lock;
            next_ctl.removal_request_irq_enable = wr_val.removal_request_irq_enable;
            next_ctl.chg_en = wr_val.chg_en;
            next_ctl.wake_en = wr_val.wake_en;
            // Power only with a device in and the lock engaged
            next_ctl.pwr = wr_val.pwr & seated & wr_val.lock;
            if (streq_ok) begin
               next_ctl.streq = wr_val.streq;
            end
         end
         if (lock_wipe) begin
            next_ctl.lock = 1'b0;
         end
         if (rem_evt) begin
            // Forced removal drops power and the request field
            next_ctl.pwr = 1'b0;
            next_ctl.streq = 3'h0;
         end
      end

      // Bay state next value, removal has the last word
      always_comb begin
         next_state = state;
         if (streq_ok) begin
            next_state = dbc_pkg::dbc_bay_state_type'(wr_val.streq);
         end
         if (ins_fire & ctl.chg_en) begin
            next_state = dbc_pkg::ST_INSERTED;
         end
         if (remreq_evt & ctl.removal_request_irq_enable) begin
            next_state = dbc_pkg::ST_REM_ALLOWED;
         end
         if (rem_evt) begin
            next_state = dbc_pkg::ST_EMPTY;
         end
      end

      // Control, state and sticky flags; a set beats a same-cycle clear
      always_ff @(posedge core_clk) begin
         if (int_rst) begin
            ctl <= dbc_pkg::CTL_RESET;
            state <= dbc_pkg::ST_EMPTY;
            remreq_flag <= 1'b0;
            chg_flag <= 1'b0;
            rr_prev <= 1'b1;
         end else begin
            ctl <= next_ctl;
            state <= next_state;
            remreq_flag <= remreq_evt | (remreq_flag &
               ~(wr_sts & reg_wdata[dbc_pkg::STS_REMREQ_BIT]));
            chg_flag <= chg_set | (chg_flag &
               ~(wr_sts & reg_wdata[dbc_pkg::STS_CHG_BIT]));
            rr_prev <= rr_n[b];
         end
      end

      // Presence debounce: input must hold its new level one tick
      always_ff @(posedge core_clk) begin
         if (int_rst) begin
            deb_cnt <= dbc_pkg::CNT_RESET;
            present_db <= 1'b0;
         end else if ((present_raw == present_db) | deb_done) begin
            deb_cnt <= dbc_pkg::CNT_RESET;
            present_db <= present_raw;
         end else begin
            deb_cnt <= deb_cnt + 32'h1;
         end
      end

      // Insertion timeout, started only after the debounce
      always_ff @(posedge core_clk) begin
         if (int_rst) begin
            waiting <= 1'b0;
            seated <= 1'b0;
            wait_cnt <= dbc_pkg::CNT_RESET;
         end else if (ins_start) begin
            waiting <= 1'b1;
            wait_cnt <= wait_len;
         end else if (cancel) begin
            waiting <= 1'b0; // Pulled early, no event at all
         end else if (ins_fire) begin
            waiting <= 1'b0;
            seated <= 1'b1;
         end else if (rem_evt) begin
            seated <= 1'b0;
         end else if (waiting) begin
            wait_cnt <= wait_cnt - 32'h1;
         end
      end

      // Solenoid pulse timer and drive, level mode follows the lock
      always_ff @(posedge core_clk) begin
         if (int_rst | lock_wipe) begin
            pulse_cnt <= dbc_pkg::CNT_RESET;
            sol_drive[b] <= 1'b0;
         end else begin
            if (pulsed & lock_fall) begin
               pulse_cnt <= pulse_len;
            end else if (pulse_cnt != 32'h0) begin
               pulse_cnt <= pulse_cnt - 32'h1;
            end
            sol_drive[b] <= pulsed ? ((pulsed & lock_fall) |
                                      (pulse_cnt > 32'h1))
                                   : next_ctl.lock;
         end
      end

      // Power enable mirrors the power control bit
      always_ff @(posedge core_clk) begin
         if (int_rst) begin
            pwr_drive[b] <= 1'b0;
         end else begin
            pwr_drive[b] <= next_ctl.pwr;
         end
      end

      assign ctl_word[b] = ctl;
      // Presence bits straight from the synced pins, inverted
      assign sts_word[b] = {1'b0, state, remreq_flag, chg_flag,
                            ~ser_n[b], ~per_n[b]};
      // Late enable still raises the alert on a pending flag
      assign alert_term[b] = (remreq_flag & ctl.removal_request_irq_enable) |
                             (chg_flag & ctl.chg_en);
   end

   assign power_enable_output = {pwr_drive[1], pwr_drive[0]};
   assign solenoid_drive_output = {sol_drive[1], sol_drive[0]};

   // Read mux, reserved and unmapped space reads zero
   always_comb begin
      next_rdata = 32'h0;
      unique case (reg_addr)
         dbc_pkg::OFS_CTL0: next_rdata = {24'h0, ctl_word[0]};
         dbc_pkg::OFS_STS0: next_rdata = {24'h0, sts_word[0]};
         dbc_pkg::OFS_CTL1: next_rdata = {24'h0, ctl_word[1]};
         dbc_pkg::OFS_STS1: next_rdata = {24'h0, sts_word[1]};
         dbc_pkg::OFS_CFG: next_rdata = dbc_pkg::CFG_RESET;
         dbc_pkg::OFS_FEAT: next_rdata = {24'h0, feat};
         default: next_rdata = 32'h0;
      endcase
   end

   // Registered read data and alert
   always_ff @(posedge core_clk) begin
      if (int_rst) begin
         reg_rdata <= 32'h0;
         alert_output <= 1'b0;
      end else begin
         reg_rdata <= next_rdata;
         alert_output <= alert_term[0] | alert_term[1];
      end
   end

endmodule

// >>> verif/dbc_bay_status_properties.sv
// Port-level assertions for the bay status block
`timescale 1ns/100ps
module dbc_bay_status_chk #(
   parameter logic [31:0] TICK_CYCLES = 32'h14
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic reset_pin_n,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic [31:0] reg_rdata,
   input wire logic alert_output,
   input wire logic [1:0] power_enable_output,
   input wire logic [1:0] solenoid_drive_output,
   input wire logic pointer_reset
);
   logic fw_seen; // First feature write taken
   logic [7:0] feat_val; // Write-once byte as held
   logic lock0; // Bay 0 lock bit shadow
   logic [31:0] run_cnt; // Cycles solenoid 0 high in pulsed mode
   wire feat_wr = reg_wr && reg_addr == dbc_pkg::OFS_FEAT;
   wire ctl0_wr = reg_wr && reg_addr == dbc_pkg::OFS_CTL0;
   wire pulsed = feat_val[4:1] != 4'h0;
   wire [31:0] unit = feat_val[0] ? TICK_CYCLES * 16 : TICK_CYCLES;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // Shadows; internal reset also reopens the write-once byte
   always_ff @(posedge core_clk) begin
      if (rst || pointer_reset) begin
         fw_seen <= 1'b0;
         feat_val <= 8'h00;
         lock0 <= 1'b0;
      end else begin
         if (feat_wr && !fw_seen) begin
            fw_seen <= 1'b1;
            feat_val <= reg_wdata[7:0];
         end
         // Lock write wins; first feature write clears it
         if (ctl0_wr) begin
            lock0 <= reg_wdata[7];
         end else if (feat_wr && !fw_seen) begin
            lock0 <= 1'b0;
         end
      end
   end

   // Length of the current pulse, zero while low
   always_ff @(posedge core_clk) begin
      if (rst || !solenoid_drive_output[0] || !pulsed) begin
         run_cnt <= 32'h0;
      end else begin
         run_cnt <= run_cnt + 32'h1;
      end
   end

   chk_feat_upper: assert property (
      $past(reg_addr) == dbc_pkg::OFS_FEAT |-> reg_rdata[31:8] == 24'h0)
      else $error("Feature upper bits not zero");
   chk_cfg_value: assert property (
      !pointer_reset && !$past(pointer_reset)
      && $past(reg_addr) == dbc_pkg::OFS_CFG
      |-> reg_rdata == dbc_pkg::CFG_RESET)
      else $error("Config register wrong");
   chk_feat_once: assert property (
      fw_seen && $past(fw_seen, 2) && !pointer_reset
      && $past(reg_addr) == dbc_pkg::OFS_FEAT
      |-> reg_rdata[7:0] == feat_val)
      else $error("Feature byte changed after first write");
   chk_reset_quiet: assert property (
      pointer_reset && $past(pointer_reset)
      |-> !alert_output && power_enable_output == 2'h0
      && solenoid_drive_output == 2'h0)
      else $error("Output active during reset");
   chk_por_hold: assert property (
      $fell(rst) |-> pointer_reset [*2])
      else $error("Reset hold too short");
   chk_pin_reset: assert property (
      !reset_pin_n [*6] |-> pointer_reset)
      else $error("Reset pin not honoured");
   chk_level_follow: assert property (
      !pulsed && ctl0_wr && !pointer_reset
      |-> ##2 solenoid_drive_output[0] == $past(reg_wdata[7], 2))
      else $error("Level solenoid not following lock");
   chk_pulse_start: assert property (
      pulsed && ctl0_wr && lock0 && !reg_wdata[7]
      |-> ##2 solenoid_drive_output[0])
      else $error("No pulse on lock fall");
   chk_pulse_len: assert property (
      $fell(solenoid_drive_output[0]) && pulsed && $past(fw_seen, 3)
      |-> run_cnt == 32'(feat_val[4:1]) * unit)
      else $error("Solenoid pulse length wrong");
endmodule

bind dbc_bay_status dbc_bay_status_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .core_clk(core_clk), .rst(rst), .reset_pin_n(reset_pin_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rdata(reg_rdata), .alert_output(alert_output),
   .power_enable_output(power_enable_output),
   .solenoid_drive_output(solenoid_drive_output),
   .pointer_reset(pointer_reset));

// >>> verif/dbc_bay_model.sv
// Bay side model: presence contacts and removal buttons
`timescale 1ns/100ps
module dbc_bay_model (
   input wire logic [1:0] ser_in,
   input wire logic [1:0] per_in,
   input wire logic [1:0] press,
   output logic [1:0] serial_bus_present_pin_n,
   output logic [1:0] peripheral_present_pin_n,
   output logic [1:0] removal_request_pin_n
);
   logic link_clk = 1'b0; // Own contact timing, separate from core_clk but in fixed phase with it
   // 200 ns period, eight core cycles, so pin changes always land on a core_clk falling edge
   always #100 link_clk = ~link_clk;
   // Pins are pulled up, so a released contact reads high
   initial begin
      serial_bus_present_pin_n = 2'h3;
      peripheral_present_pin_n = 2'h3;
      removal_request_pin_n = 2'h3;
   end
   // Active-low contacts follow the requested bay contents
   always @(posedge link_clk) begin
      serial_bus_present_pin_n <= ~ser_in;
      peripheral_present_pin_n <= ~per_in;
      removal_request_pin_n <= ~press;
   end
endmodule

// >>> verif/dbc_bay_status_bench.sv
// Self-checking bench for the bay status block
`timescale 1ns/100ps
`define CHK(got, exp) begin \
   n_checks++; \
   if ((got) !== (exp)) begin \
      err_count++; \
      $display("ERROR t=%0t got %h exp %h", $time, got, exp); \
   end \
end
module dbc_bay_status_bench;
   localparam logic [31:0] TICKS = 32'h14; // Short tick keeps runs brief
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic reset_pin_n = 1'b1;
   logic strap_lo = 1'b0;
   logic strap_hi = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic [1:0] ser_in = 2'h0; // Serial device seated per bay
   logic [1:0] per_in = 2'h0; // Peripheral seated per bay
   logic [1:0] press = 2'h0; // Removal button held per bay
   logic [1:0] rq_n, ser_n, per_n;
   logic [31:0] reg_rdata;
   logic alert_output, pointer_reset;
   logic [1:0] power_enable_output, solenoid_drive_output;
   logic [1:0] slave_addr_select;
   int err_count = 0;
   int n_checks = 0;
   int n;

   // 40 MHz core clock
   always #12.5 core_clk = ~core_clk;

   dbc_bay_status #(.TICK_CYCLES(TICKS)) u_dut (
      .core_clk(core_clk), .rst(rst), .reset_pin_n(reset_pin_n),
      .removal_request_pin_n(rq_n), .serial_bus_present_pin_n(ser_n),
      .peripheral_present_pin_n(per_n),
      .address_select_low_pin(strap_lo),
      .address_select_high_pin(strap_hi),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rdata(reg_rdata), .alert_output(alert_output),
      .power_enable_output(power_enable_output),
      .solenoid_drive_output(solenoid_drive_output),
      .slave_addr_select(slave_addr_select),
      .pointer_reset(pointer_reset));

   dbc_bay_model u_bay (
      .ser_in(ser_in), .per_in(per_in), .press(press),
      .serial_bus_present_pin_n(ser_n),
      .peripheral_present_pin_n(per_n),
      .removal_request_pin_n(rq_n));

   // Verdict and end of run
   task automatic finish_test;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Wait cycles, then step off the edge
   task automatic cyc(input int c);
      repeat (c) @(posedge core_clk);
      #1;
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data is registered, so allow it a full cycle
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      cyc(2);
      `CHK(reg_rdata, e)
   endtask

   // Bounded wait for the alert; returns cycles waited
   task automatic wait_alert(output int c);
      c = 0;
      while (alert_output !== 1'b1 && c < 2000) begin
         cyc(1);
         c++;
      end
   endtask

   // Length of the next solenoid 0 pulse
   task automatic high_run(output int c);
      c = 0;
      #1;
      repeat (4) if (solenoid_drive_output[0] !== 1'b1) cyc(1);
      while (solenoid_drive_output[0] === 1'b1 && c < 1000) begin
         cyc(1);
         c++;
      end
   endtask

   // Hang guard, well beyond the roughly 1500 cycles needed
   initial begin
      repeat (6000) @(posedge core_clk);
      err_count++;
      finish_test;
   end

   initial begin
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      cyc(6);
      `CHK(slave_addr_select, 2'h2)
      `CHK(alert_output, 1'b0)
      `CHK({power_enable_output, solenoid_drive_output}, 4'h0)
      rdchk(dbc_pkg::OFS_FEAT, 32'h0);
      rdchk(dbc_pkg::OFS_CFG, dbc_pkg::CFG_RESET);
      rdchk(dbc_pkg::OFS_STS0, 32'h0);
      rdchk(dbc_pkg::OFS_CTL1, 32'h0);
      rdchk(8'h04, 32'h0);
      // Level mode, then first feature write drops the lock
      wr(dbc_pkg::OFS_CTL0, 32'h80);
      cyc(3);
      `CHK(solenoid_drive_output, 2'h1)
      wr(dbc_pkg::OFS_FEAT, 32'hffffff24);
      cyc(3);
      `CHK(solenoid_drive_output, 2'h0)
      rdchk(dbc_pkg::OFS_CTL0, 32'h0);
      wr(dbc_pkg::OFS_FEAT, 32'h000000ff);
      rdchk(dbc_pkg::OFS_FEAT, 32'h24);
      // Pulsed mode: only a one-to-zero lock write fires
      wr(dbc_pkg::OFS_CTL0, 32'h80);
      cyc(3);
      `CHK(solenoid_drive_output, 2'h0)
      wr(dbc_pkg::OFS_CTL0, 32'h00);
      high_run(n);
      `CHK(n, 40)
      // Insertion: debounce plus one timeout step
      wr(dbc_pkg::OFS_CTL0, 32'h04);
      ser_in[0] <= 1'b1;
      wait_alert(n);
      `CHK(n >= 340 && n < 380, 1'b1)
      rdchk(dbc_pkg::OFS_STS0, 32'h16);
      wr(dbc_pkg::OFS_STS0, 32'h04);
      rdchk(dbc_pkg::OFS_STS0, 32'h12);
      `CHK(alert_output, 1'b0)
      // Software request: Enabled taken, reserved code refused
      wr(dbc_pkg::OFS_CTL0, 32'h24);
      wr(dbc_pkg::OFS_CTL0, 32'h74);
      rdchk(dbc_pkg::OFS_STS0, 32'h22);
      // Removal button with its enable set
      wr(dbc_pkg::OFS_CTL0, 32'h0c);
      press[0] <= 1'b1;
      wait_alert(n);
      press[0] <= 1'b0;
      `CHK(n < 40, 1'b1)
      rdchk(dbc_pkg::OFS_STS0, 32'h4a);
      wr(dbc_pkg::OFS_STS0, 32'h08);
      rdchk(dbc_pkg::OFS_STS0, 32'h42);
      // Removal while allowed and wake off: no change flag
      wr(dbc_pkg::OFS_CTL0, 32'h04);
      ser_in[0] <= 1'b0;
      cyc(60);
      rdchk(dbc_pkg::OFS_STS0, 32'h0);
      `CHK(alert_output, 1'b0)
      // Bay 1 with change enable off: flag only, state kept
      per_in[1] <= 1'b1;
      cyc(420);
      rdchk(dbc_pkg::OFS_STS1, 32'h05);
      `CHK(alert_output, 1'b0)
      wr(dbc_pkg::OFS_STS1, 32'h04);
      per_in[1] <= 1'b0;
      cyc(60);
      rdchk(dbc_pkg::OFS_STS1, 32'h04);
      // Pin reset resamples straps and reopens the feature byte
      @(posedge core_clk);
      reset_pin_n <= 1'b0;
      strap_lo <= 1'b1;
      strap_hi <= 1'b0;
      repeat (6) @(posedge core_clk);
      reset_pin_n <= 1'b1;
      cyc(10);
      `CHK(slave_addr_select, 2'h1)
      rdchk(dbc_pkg::OFS_FEAT, 32'h0);
      wr(dbc_pkg::OFS_FEAT, 32'h03);
      rdchk(dbc_pkg::OFS_FEAT, 32'h03);
      // Long pulse unit, one count is sixteen ticks
      wr(dbc_pkg::OFS_CTL0, 32'h80);
      wr(dbc_pkg::OFS_CTL0, 32'h00);
      high_run(n);
      `CHK(n, 320)
      // Zero timeout: alert follows the debounce alone
      wr(dbc_pkg::OFS_CTL0, 32'h04);
      ser_in[0] <= 1'b1;
      wait_alert(n);
      `CHK(n >= 20 && n < 40, 1'b1)
      finish_test;
   end
endmodule
